//--- verilog/sar_adc_consts.svh
// Register offsets, field positions, widths and reset values of the converter controller.
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ==========================================================
// Register offsets
`define OFF_CONVERSION_RESULT 4'h0
`define OFF_CONVERTER_STATE 4'h4
`define OFF_CONVERTER_CONTROL 4'h8
`define OFF_POWERUP_START_DELAY 4'hc

// ==========================================================
// Field layout
`define RESULT_WIDTH 10
`define CHAN_WIDTH 3
`define DELAY_WIDTH 6
`define CTRL_CHAN_LSB 0
`define CTRL_POWER_BIT 3
`define CTRL_INT_EN_BIT 5
`define CTRL_DONE_BIT 6
`define STATE_BUSY_BIT 0

// ==========================================================
// Reset values and timing
`define RESET_RESULT 10'h000
`define RESET_CHAN 3'h0
`define RESET_DELAY 6'h00
`define START_EXTRA_CYCLES 7'h02

`endif

//--- verilog/sar_adc_pkg.sv
// Types shared by the converter controller files.
package sar_adc_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_WAIT = 3'b010,
        SEQ_BUSY = 3'b100
    } seq_state_t;

    // ==========================================================
    // Signals driven toward the analog converter macro
    typedef struct packed {
        logic power;
        logic start;
        logic [2:0] channel_code;
    } conv_drive_t;

endpackage

//--- verilog/level_sync.sv
// Two-stage synchroniser for levels arriving from the converter macro.
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule

`default_nettype wire

//--- verilog/sar_adc_controller.sv
// Single-sample sequencer and APB register file for a six-input 10-bit converter.
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_consts.svh"

module sar_adc_controller (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output sar_adc_pkg::conv_drive_t conv_out,
    input wire logic conv_eoc,
    input wire logic [9:0] conv_data,
    output logic irq
);

    // ==========================================================
    // Converter inputs
    // The data word is synchronised alongside the strobe so both arrive in the same cycle.
    logic [10:0] eoc_data_s;
    logic eoc_prev;
    logic eoc_rise;

    level_sync #(
        .WIDTH(11)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({conv_eoc, conv_data}),
        .sync_out(eoc_data_s)
    );

    assign eoc_rise = eoc_data_s[10] & ~eoc_prev;

    // ==========================================================
    // Register file and sequencer state
    sar_adc_pkg::seq_state_t state;
    sar_adc_pkg::seq_state_t next_state;
    sar_adc_pkg::conv_drive_t next_conv_out;
    logic [9:0] result;
    logic [9:0] next_result;
    logic [5:0] delay;
    logic [5:0] next_delay;
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic int_en;
    logic next_int_en;
    logic done;
    logic next_done;
    logic next_irq;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup;
    logic wr;
    logic in_progress;

    function automatic logic mapped(input logic [3:0] addr);
        mapped = (addr == `OFF_CONVERSION_RESULT) || (addr == `OFF_CONVERTER_STATE) ||
                 (addr == `OFF_CONVERTER_CONTROL) || (addr == `OFF_POWERUP_START_DELAY);
    endfunction

    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;
    assign in_progress = (state != sar_adc_pkg::SEQ_IDLE);

    always_comb begin
        next_state = state;
        next_conv_out = conv_out;
        next_conv_out.start = 1'b0;
        next_result = result;
        next_delay = delay;
        next_cnt = cnt;
        next_int_en = int_en;
        next_done = done;
        next_prdata = 32'h0000_0000;
        next_pready = setup;
        next_pslverr = setup & ~mapped(paddr);

        // One wait-free access: data and ready are registered in the setup cycle.
        if (setup && !pwrite) begin
            unique case (paddr)
                `OFF_CONVERSION_RESULT: next_prdata = {22'h000000, result};
                `OFF_CONVERTER_STATE: next_prdata = {31'h00000000, in_progress};
                `OFF_CONVERTER_CONTROL: next_prdata = {25'h0000000, done, int_en, 1'b0,
                                                       conv_out.power, conv_out.channel_code};
                `OFF_POWERUP_START_DELAY: next_prdata = {26'h0000000, delay};
                default: next_prdata = 32'h0000_0000;
            endcase
        end

        if (wr && paddr == `OFF_CONVERTER_CONTROL) begin
            next_conv_out.channel_code = pwdata[`CTRL_CHAN_LSB +: `CHAN_WIDTH];
            next_int_en = pwdata[`CTRL_INT_EN_BIT];
            if (!pwdata[`CTRL_DONE_BIT]) begin
                next_done = 1'b0;
            end
            // power control, a rising write restarts the sequence
            next_conv_out.power = pwdata[`CTRL_POWER_BIT];
            if (!pwdata[`CTRL_POWER_BIT]) begin
                next_state = sar_adc_pkg::SEQ_IDLE;
            end else if (!conv_out.power) begin
                next_state = sar_adc_pkg::SEQ_WAIT;
                next_cnt = 7'h00;
            end
        end
        if (wr && paddr == `OFF_POWERUP_START_DELAY) begin
            next_delay = pwdata[`DELAY_WIDTH-1:0];
        end

        if (!(wr && paddr == `OFF_CONVERTER_CONTROL)) begin
            unique case (state)
                sar_adc_pkg::SEQ_IDLE: begin
                end
                sar_adc_pkg::SEQ_WAIT: begin
                    next_cnt = cnt + 7'h01;
                    // start lands delay plus two cycles after power-up
                    if (cnt == {1'b0, delay} + `START_EXTRA_CYCLES - 7'h01) begin
                        next_conv_out.start = 1'b1;
                        next_state = sar_adc_pkg::SEQ_BUSY;
                    end
                end
                sar_adc_pkg::SEQ_BUSY: begin
                    if (eoc_rise) begin
                        next_state = sar_adc_pkg::SEQ_IDLE;
                    end
                end
                default: next_state = sar_adc_pkg::SEQ_IDLE;
            endcase
        end

        // capture converter data at the end of conversion
        // The capture also ends the busy phase, so a control write in this cycle cannot strand the sequencer.
        if (eoc_rise && state == sar_adc_pkg::SEQ_BUSY) begin
            next_result = eoc_data_s[9:0];
            next_state = sar_adc_pkg::SEQ_IDLE;
            // the set wins over a clearing write in the same cycle
            next_done = 1'b1;
        end

        // level interrupt from done and enable
        next_irq = next_done & next_int_en;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= sar_adc_pkg::SEQ_IDLE;
            conv_out <= '0;
            result <= `RESET_RESULT;
            delay <= `RESET_DELAY;
            cnt <= 7'h00;
            int_en <= 1'b0;
            done <= 1'b0;
            irq <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            eoc_prev <= 1'b0;
        end else begin
            state <= next_state;
            conv_out <= next_conv_out;
            result <= next_result;
            delay <= next_delay;
            cnt <= next_cnt;
            int_en <= next_int_en;
            done <= next_done;
            irq <= next_irq;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            eoc_prev <= eoc_data_s[10];
        end
    end

    // ==========================================================
    // Checks
    // Cycles since power came up, saturating, used only by the delay check.
    logic [6:0] pu_cnt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pu_cnt <= 7'h00;
        end else if (!conv_out.power) begin
            pu_cnt <= 7'h00;
        end else if (pu_cnt != 7'h7f) begin
            pu_cnt <= pu_cnt + 7'h01;
        end
    end

    a_result_upper_zero: assert property (@(posedge clk) disable iff (rst)
        pready && !pwrite && paddr == `OFF_CONVERSION_RESULT |-> prdata[31:10] == 22'h000000)
        else $error("result upper bits not zero");
    a_capture_data: assert property (@(posedge clk) disable iff (rst)
        eoc_rise && state == sar_adc_pkg::SEQ_BUSY |=> result == $past(eoc_data_s[9:0]))
        else $error("result not captured at end strobe");
    a_status_busy: assert property (@(posedge clk) disable iff (rst)
        conv_out.start |-> in_progress ##1 (in_progress || $past(eoc_rise) || !conv_out.power))
        else $error("status not busy around start");
    a_done_set: assert property (@(posedge clk) disable iff (rst)
        eoc_rise && state == sar_adc_pkg::SEQ_BUSY |=> done ##1 irq == int_en)
        else $error("done flag not set at end");
    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        1'b1 |-> irq == (done && int_en))
        else $error("interrupt without done flag");
    a_power_gate_start: assert property (@(posedge clk) disable iff (rst)
        conv_out.start |-> conv_out.power && $past(conv_out.power))
        else $error("start while powered down");
    a_start_delay: assert property (@(posedge clk) disable iff (rst)
        $rose(conv_out.start) |-> pu_cnt == {1'b0, delay} + `START_EXTRA_CYCLES)
        else $error("start delay wrong");
    a_start_pulse: assert property (@(posedge clk) disable iff (rst)
        conv_out.start |=> !conv_out.start [*2])
        else $error("start longer than one cycle");
    a_int_enable: assert property (@(posedge clk) disable iff (rst)
        !int_en && !$past(int_en) |-> !irq)
        else $error("interrupt while disabled");

endmodule

`default_nettype wire

//--- dv/sar_converter_model.sv
// Behavioural model of the six-input converter macro facing the controller.
`timescale 1ns/1ns
`default_nettype none

module sar_converter_model (
    input wire logic clk,
    input wire sar_adc_pkg::conv_drive_t conv,
    input wire logic [9:0] next_data,
    input wire logic [7:0] latency,
    output logic eoc,
    output logic [9:0] data
);
    int count;

    initial begin
        count = 0;
        eoc = 1'b0;
        data = 10'h2a5;
    end

    // ==========================================================
    // Conversion timing
    // one start converts once
    always @(posedge clk) begin
        if (conv.power !== 1'b1)
            count <= 0;
        else if (conv.start === 1'b1 && count == 0)
            count <= latency + 4;
        else if (count > 0)
            count <= count - 1;
    end

    // Data toggles outside the valid window, so a late or early capture shows up.
    // data valid from eoc rise
    always @(posedge clk) begin
        eoc <= (count >= 2 && count <= 5);
        if (count >= 2 && count <= 5)
            data <= next_data;
        else
            data <= ~data;
    end
endmodule

`default_nettype wire

//--- dv/sar_adc_controller_tb.sv
// Self-checking bench for the converter controller against a converter macro model.
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_consts.svh"

module sar_adc_controller_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, conv_eoc, irq;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] conv_data, next_data;
    logic [7:0] latency;
    logic [15:0] lf;
    sar_adc_pkg::conv_drive_t conv_out;
    int mismatches, checked;
    logic [9:0] expq[$];

    sar_adc_controller u_sar_adc_controller (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_out(conv_out), .conv_eoc(conv_eoc), .conv_data(conv_data), .irq(irq));
    sar_converter_model u_sar_converter_model (.clk(clk), .conv(conv_out), .next_data(next_data),
        .latency(latency), .eoc(conv_eoc), .data(conv_data));

    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic summarize();
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Register bus
    task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(negedge clk);
        psel = 1'b1;
        penable = 1'b0;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge clk);
        penable = 1'b1;
        n = 0;
        @(posedge clk);
        // The request stands until the edge that samples ready high, and the answer is taken there.
        while (pready !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        r = prdata;
        e = pslverr;
        check({31'h0, pready}, 32'h1);
        @(negedge clk);
        psel = 1'b0;
        penable = 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, 32'h0);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask

    // ==========================================================
    // One single-sample conversion
    task automatic convert(input logic [2:0] ch, input logic ie, input logic [5:0] dly);
        logic [31:0] junk, base;
        int first, starts;
        junk = {lf, lf} & 32'hffff_ffd0;
        base = {26'h0, ie, 2'b00, ch};
        lf = step(lf);
        wr(`OFF_POWERUP_START_DELAY, {junk[31:6], dly});
        rd(`OFF_POWERUP_START_DELAY, {26'h0, dly});
        wr(`OFF_CONVERTER_CONTROL, junk);
        wr(`OFF_CONVERTER_CONTROL, junk | base);
        rd(`OFF_CONVERTER_CONTROL, base);
        next_data = lf[9:0];
        latency = {5'h0, lf[12:10]} + 8'h1;
        expq.push_back(lf[9:0]);
        lf = step(lf);
        wr(`OFF_CONVERTER_CONTROL, base | 32'h8);
        first = -1;
        starts = 0;
        check({29'h0, conv_out.channel_code}, {29'h0, ch});
        check({31'h0, conv_out.power}, 32'h1);
        for (int j = 0; j < 90; j++) begin
            if (conv_out.start === 1'b1) begin
                starts++;
                if (first < 0)
                    first = j;
            end
            @(negedge clk);
        end
        check(first, dly + 2);
        check(starts, 1);
        rd(`OFF_CONVERTER_STATE, 32'h0);
        rd(`OFF_CONVERSION_RESULT, {22'h0, expq.pop_front()});
        rd(`OFF_CONVERTER_CONTROL, base | 32'h48);
        check({31'h0, irq}, {31'h0, ie});
        wr(`OFF_CONVERTER_CONTROL, base | 32'h8);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        rd(`OFF_CONVERTER_CONTROL, base | 32'h8);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #100000;
        mismatches++;
        summarize();
    end

    initial begin
        logic [31:0] r;
        logic e;
        int n;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 4'h0;
        pwdata = 32'h0;
        next_data = 10'h0;
        latency = 8'h1;
        lf = 16'd10916;
        mismatches = 0;
        checked = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        check({26'h0, conv_out, irq}, 32'h0);
        for (int a = 0; a < 16; a += 4) rd(a[3:0], 32'h0);
        apb(1'b0, 4'h2, 32'h0, r, e);
        check({r[31:1], r[0] | e}, 32'h1);
        wr(`OFF_CONVERSION_RESULT, {lf, lf});
        rd(`OFF_CONVERSION_RESULT, 32'h0);
        for (int c = 0; c < 6; c++) convert(c[2:0], c[0], c == 0 ? 6'h00 : (c == 5 ? 6'h3f : lf[15:10]));
        // A reset in mid-run must clear the result, power and enable left by the runs above.
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check({26'h0, conv_out, irq}, 32'h0);
        for (int a = 0; a < 16; a += 4) rd(a[3:0], 32'h0);
        // An abort before the start pulse must leave the converter idle.
        wr(`OFF_POWERUP_START_DELAY, 32'h3f);
        wr(`OFF_CONVERTER_CONTROL, 32'h8);
        rd(`OFF_CONVERTER_STATE, 32'h1);
        wr(`OFF_CONVERTER_CONTROL, 32'h0);
        n = 0;
        repeat (80) begin
            @(negedge clk);
            if (conv_out.start === 1'b1)
                n++;
        end
        check(n, 0);
        rd(`OFF_CONVERTER_STATE, 32'h0);
        summarize();
    end
endmodule

`default_nettype wire
